// ==== hdl/adc_serial_readout_port.v ====
/*
  Serial readout and conversion control of a 16-bit converter, device side.
  Assumes the pins are asynchronous to core_clk and slow enough (link clock
  period 400 ns) to be sampled; results come in through a FIFO from the
  converter core, which is stalled by its ready.
*/
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module adc_serial_readout_port
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Host pins
  input wire conversion_start_pin,
  input wire sclk,
  input wire din,
  output reg dout,
  output reg dout_oe,
  // Converter core results
  input wire result_valid,
  output wire result_ready,
  input wire [15:0] result_data,
  // Converter control
  output reg conv_active,
  output reg power_down,
  output reg [1:0] mode
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_READ = 2'h2;

  reg cnv_s1_q;
  reg cnv_s2_q;
  reg cnv_s3_q;
  reg clk_s1_q;
  reg clk_s2_q;
  reg clk_s3_q;
  reg din_s1_q;
  reg din_s2_q;
  reg din_s3_q;
  reg [1:0] state_q;
  reg [`CONV_CNT_W-1:0] conv_cnt_q;
  reg [`RESULT_BITS-1:0] shift_q;
  reg [`BIT_CNT_W-1:0] bit_cnt_q;
  reg frame_done_q;
  reg cs_seen_q;
  reg drop_q;
  wire cnv_rise;
  wire cnv_fall;
  wire clk_fall;
  wire din_rise;
  wire din_fall;
  wire fifo_valid;
  wire fifo_ready;
  wire [15:0] fifo_data;
  wire cs_active;

  result_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // Two flops per pin before use; the third stage is only an edge history.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      cnv_s1_q <= 1'b0;
      cnv_s2_q <= 1'b0;
      cnv_s3_q <= 1'b0;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      // The input idles high; a low reset value would fake an edge.
      din_s1_q <= 1'b1;
      din_s2_q <= 1'b1;
      din_s3_q <= 1'b1;
    end
    else
    begin
      cnv_s1_q <= conversion_start_pin;
      cnv_s2_q <= cnv_s1_q;
      cnv_s3_q <= cnv_s2_q;
      clk_s1_q <= sclk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      din_s1_q <= din;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  assign cnv_rise = cnv_s2_q && !cnv_s3_q;
  assign cnv_fall = !cnv_s2_q && cnv_s3_q;
  assign clk_fall = !clk_s2_q && clk_s3_q;
  assign din_rise = din_s2_q && !din_s3_q;
  assign din_fall = !din_s2_q && din_s3_q;

  // A result is taken from the FIFO at the end of each conversion.
  assign fifo_ready = (state_q == ST_CONV) &&
    (conv_cnt_q == {`CONV_CNT_W{1'b0}});

  assign cs_active = (mode == `MODE_3WIRE) ? !cnv_s2_q :
    (mode == `MODE_4WIRE) ? !din_s2_q : 1'b1;

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      conv_cnt_q <= {`CONV_CNT_W{1'b0}};
      shift_q <= {`RESULT_BITS{1'b0}};
      bit_cnt_q <= {`BIT_CNT_W{1'b0}};
      frame_done_q <= 1'b0;
      cs_seen_q <= 1'b0;
      drop_q <= 1'b0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      conv_active <= 1'b0;
      power_down <= 1'b1;
      mode <= `MODE_3WIRE;
    end
    else
    begin
      if (cnv_rise)
      begin
        state_q <= ST_CONV;
        mode <= din_s2_q ? `MODE_3WIRE : `MODE_DAISY;
        conv_cnt_q <= `CONV_CYCLES;
        conv_active <= 1'b1;
        power_down <= 1'b0;
        dout_oe <= 1'b0;
        frame_done_q <= 1'b0;
        cs_seen_q <= 1'b0;
        bit_cnt_q <= {`BIT_CNT_W{1'b0}};
      end
      else
      begin
        case (state_q)
          ST_CONV:
          begin
            if (conv_cnt_q != {`CONV_CNT_W{1'b0}})
            begin
              conv_cnt_q <= conv_cnt_q - 1'b1;
            end
            else
            begin
              shift_q <= fifo_valid ? fifo_data : {`RESULT_BITS{1'b0}};
              drop_q <= !fifo_valid;
              conv_active <= 1'b0;
              power_down <= 1'b1;
              state_q <= ST_READ;
            end
          end
          ST_READ:
          begin
            if (!frame_done_q &&
              ((cnv_fall && mode == `MODE_3WIRE) ||
              (din_fall && cnv_s2_q && mode != `MODE_DAISY) ||
              (mode == `MODE_DAISY && !cs_seen_q)))
            begin
              cs_seen_q <= 1'b1;
              dout_oe <= 1'b1;
              dout <= shift_q[`RESULT_BITS-1];
              if (din_fall && cnv_s2_q && mode != `MODE_DAISY)
              begin
                mode <= `MODE_4WIRE;
              end
            end
            if (!cs_active && mode != `MODE_DAISY &&
              !(cnv_fall || din_fall))
            begin
              dout_oe <= 1'b0;
            end
            if (clk_fall && cs_active && cs_seen_q && !frame_done_q)
            begin
              // advance one bit per falling edge
              shift_q <= {shift_q[`RESULT_BITS-2:0],
                (mode == `MODE_DAISY) ? din_s2_q : 1'b0};
              dout <= shift_q[`RESULT_BITS-2];
              if (bit_cnt_q == 5'h0F)
              begin
                // Daisy mode keeps shifting so chained bits pass through.
                if (mode != `MODE_DAISY)
                begin
                  frame_done_q <= 1'b1;
                  dout_oe <= 1'b0;
                end
              end
              else
              begin
                bit_cnt_q <= bit_cnt_q + 1'b1;
              end
            end
          end
          default:
          begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // adc_serial_readout_port

// ==== hdl/adc_port_defines.vh ====
/*
  Constants for the serial readout port: timing counts, widths, modes.
  Assumes a 20 MHz core clock; counts are derived from times in ns.
*/
//
// Summary of operation
// - 3-wire: output drives MSB after start falls
// - 3-wire: release on start rise or last fall
// - Advance output bit on each falling clock
// - 4-wire: input falling enables output, MSB valid
// - 4-wire: release on input rise or last fall
// - Daisy-chain: capture input on falling clock
// - Mode from input level at conversion start
// - 3-wire: start pin acts as chip select
// - 4-wire: input pin acts as chip select
// - Power down after conversion until next start
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

`define CLK_PERIOD_NS 50
`define RESULT_BITS 16
`define BIT_CNT_W 5
`define FIFO_WIDTH 16
`define FIFO_DEPTH 32
`define FIFO_AW 5
// Longest conversion time; the result is ready no later than this.
`define CONV_TIME_NS 930
// Conversion time in core clocks, 930 ns over 50 ns rounded down.
`define CONV_CYCLES 6'h12
`define CONV_CNT_W 6
// Modes as stored.
`define MODE_3WIRE 2'h0
`define MODE_4WIRE 2'h1
`define MODE_DAISY 2'h2

`endif

// ==== hdl/result_fifo.v ====
/*
  Synchronous FIFO with valid/ready on both sides, data out registered.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module result_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
)
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  reg out_valid_q;
  wire [AW:0] count;
  wire [AW:0] held;
  wire push;
  wire pop_mem;
  assign count = wr_ptr_q - rd_ptr_q;
  // The output register counts as a slot, so no more than DEPTH words wait.
  assign held = count + {{AW{1'b0}}, out_valid_q};
  assign in_ready = (held != DEPTH[AW:0]);
  assign out_valid = out_valid_q;
  assign push = in_valid && in_ready;
  // The output register refills when it is empty or being taken and the memory holds a word.
  assign pop_mem = (count != {(AW+1){1'b0}}) &&
    (!out_valid_q || out_ready);
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr_q[AW-1:0]] <= in_data;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_mem)
      begin
        out_data <= mem[rd_ptr_q[AW-1:0]];
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule // result_fifo

// ==== verif/adc_port_sva.sv ====
/*
  Checker on the pins of the serial readout port.
  Assumes pins change slowly compared with core_clk.
*/
`timescale 1ns/1ps
module adc_port_sva
(
  // Clock and reset
  input wire core_clk,
  input wire srst,
  // Pins and status
  input wire conversion_start_pin,
  input wire sclk,
  input wire din,
  input wire dout,
  input wire dout_oe,
  input wire conv_active,
  input wire power_down,
  input wire [1:0] mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  conv_go_a: assert property (
    $rose(conversion_start_pin) && power_down |-> ##[1:5] conv_active)
    else $error("conversion did not start");
  conv_len_a: assert property (
    $rose(conv_active) |-> conv_active [*8])
    else $error("conversion too short");
  conv_end_a: assert property (
    $rose(conv_active) |-> ##[15:22] !conv_active)
    else $error("conversion too long");
  conv_awake_a: assert property (
    conv_active |-> !power_down)
    else $error("powered down while converting");
  sleep_after_a: assert property (
    $fell(conv_active) |-> ##[0:2] power_down)
    else $error("no power down after conversion");
  bit_step_a: assert property (
    dout_oe && $past(dout_oe) && $changed(dout) |-> !$past(sclk, 3))
    else $error("output bit moved without clock fall");
  cs_open_a: assert property (
    $fell(din) && conversion_start_pin && mode != 2'h2 && !conv_active
    |-> ##[2:6] dout_oe)
    else $error("output not enabled by select");
  cs3_open_a: assert property (
    $fell(conversion_start_pin) && mode == 2'h0 && !conv_active
    |-> ##[2:6] dout_oe)
    else $error("output not enabled by start pin");
  cs_close_a: assert property (
    $rose(din) && mode == 2'h1 |-> ##[1:6] !dout_oe)
    else $error("output not released by select");
  cover property ($rose(dout_oe));
  cover property (mode == 2'h2 && dout_oe);
  cover property ($fell(conv_active));
  cover property (mode == 2'h0 && dout_oe);
endmodule // adc_port_sva

bind adc_serial_readout_port adc_port_sva i_adc_port_sva (
  .core_clk(core_clk), .srst(srst),
  .conversion_start_pin(conversion_start_pin), .sclk(sclk), .din(din),
  .dout(dout), .dout_oe(dout_oe), .conv_active(conv_active),
  .power_down(power_down), .mode(mode));

// ==== verif/host_model.sv ====
/*
  Host model: starts conversions and clocks results out.
  Assumes the bench calls frame and that core_clk runs at 20 MHz.
*/
`timescale 1ns/1ps
module host_model
(
  // Clock
  input wire core_clk,
  // Pins
  output reg conversion_start_pin,
  output reg sclk,
  output reg din,
  input wire dout,
  input wire dout_oe
);
  initial
  begin
    conversion_start_pin = 1'b0;
    sclk = 1'b0;
    din = 1'b1;
  end
  // The serial clock only runs inside a frame, 400 ns a period.
  task automatic frame(input bit dc, input bit tw, input [15:0] up,
    output [31:0] got);
    int n;
    got = 32'h0;
    n = dc ? 32 : 16;
    din <= !dc;
    repeat (2) @(posedge core_clk);
    conversion_start_pin <= 1'b1;
    repeat (40) @(posedge core_clk);
    // start pin falls as select in 3-wire
    if (tw) conversion_start_pin <= 1'b0;
    else if (!dc) din <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      sclk <= 1'b1;
      if (dc && i < 16) din <= up[15 - i];
      repeat (4) @(posedge core_clk);
      got = {got[30:0], dout_oe ? dout : !dout};
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    din <= 1'b1;
    conversion_start_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // host_model

// ==== verif/tb.sv ====
/*
  Testbench: fills the result FIFO, then reads every result out.
  Assumes the checker is bound to the port.
*/
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module tb;
  reg core_clk, srst, result_valid;
  reg [15:0] result_data;
  wire conversion_start_pin, sclk, din, dout, dout_oe;
  wire result_ready, conv_active, power_down;
  wire [1:0] mode;
  int error_cnt = 0;
  int n_tests = 0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [31:0] got;
  logic [16:0] lfsr_q = 17'h13F3D;
  function automatic [16:0] lfsr_next(input [16:0] s);
    lfsr_next = {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  adc_serial_readout_port i_adc_serial_readout_port (
    .core_clk(core_clk), .srst(srst),
    .conversion_start_pin(conversion_start_pin), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data),
    .conv_active(conv_active), .power_down(power_down), .mode(mode));
  host_model i_host_model (.core_clk(core_clk),
    .conversion_start_pin(conversion_start_pin), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done;
  end
  initial
  begin
    srst = 1'b1;
    result_valid = 1'b0;
    result_data = 16'h0000;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    result_valid <= 1'b1;
    repeat (34)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      result_data <= lfsr_q[15:0];
      @(negedge core_clk);
      if (result_ready) exp_q.push_back(result_data);
      @(posedge core_clk);
    end
    result_valid <= 1'b0;
    check("fifo depth", exp_q.size(), `FIFO_DEPTH);
    // Frame 5 is a daisy chain, frame 7 uses 3-wire select, the last one
    // finds the FIFO empty.
    for (int k = 0; k < 33; k++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      e = exp_q.size() ? exp_q.pop_front() : 16'h0000;
      i_host_model.frame(k == 5, k == 7, lfsr_q[15:0], got);
      if (k == 5)
      begin
        check("daisy data", got, {e, lfsr_q[15:0]});
        check("daisy mode", mode, `MODE_DAISY);
      end
      else
      begin
        check("result", got[15:0], e);
        if (k == 7)
          check("3-wire mode", mode, `MODE_3WIRE);
        else
          check("select mode", mode, `MODE_4WIRE);
      end
      check("power down", power_down, 1'b1);
    end
    test_done;
  end
endmodule // tb
